// >>> ars_checker.sv
// checker: port-level assertions for the converter sequencer
`timescale 1ns/100ps
module ars_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic converter_power_enable,
  input wire logic [1:0] ref_route,
  input wire logic [7:0] analog_pin_select,
  input wire logic [3:0] internal_source_select,
  input wire logic [7:0] pin_digital_disable,
  input wire logic [7:0] pin_pullup_disable,
  input wire logic sample_phase,
  input wire logic convert_phase,
  input wire logic conversion_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_conv_end;
    $fell(convert_phase) && converter_power_enable;
  endsequence
  sequence s_done_last;
    conversion_done && convert_phase;
  endsequence
  // done marks the last conversion cycle; an aborted run drops power as well
  AST_DONE_END: assert property (s_conv_end |-> $past(conversion_done))
    else $error("no done pulse in the last conversion cycle");
  AST_DONE_CAUSE: assert property ($rose(conversion_done) |-> $past(convert_phase))
    else $error("done pulse without a preceding conversion phase");
  AST_DONE_PULSE: assert property (conversion_done |=> !conversion_done)
    else $error("done held longer than one cycle");
  AST_PHASE_EXCL: assert property (!(sample_phase && convert_phase))
    else $error("sampling and conversion active together");
  AST_PHASE_ORDER: assert property ($rose(convert_phase) |-> $past(sample_phase))
    else $error("conversion phase entered without sampling");
  AST_PWR_OFF: assert property (!converter_power_enable [*3] |->
      !sample_phase && !convert_phase)
    else $error("conversion running while unpowered");
  AST_ONEHOT: assert property (
      $onehot0(analog_pin_select) && $onehot0(internal_source_select))
    else $error("more than one input selected");
  AST_SRC_EXCL: assert property (|internal_source_select |-> analog_pin_select == 8'h00)
    else $error("pin joined to an internal signal");
  AST_HOLD: assert property (sample_phase && $past(sample_phase) |->
      $stable(ref_route) && $stable(analog_pin_select) && $stable(internal_source_select))
    else $error("selection changed during sampling");
  AST_PIN_OVR: assert property (pin_digital_disable == pin_pullup_disable)
    else $error("pull-up and digital disable disagree");
  cover property (s_done_last ##1 s_conv_end);
endmodule

bind ars_sequencer ars_checker u_chk (.*);

// >>> ars_clk_div.sv
// converter clock tick generator: one system clock pulse every 2**divider cycles
`timescale 1ns/100ps
module ars_clk_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);

  logic [6:0] cnt_r;
  logic [6:0] limit;

  assign limit = 7'(({7'h00, 1'b1} << div_sel) - 8'h01);

  // counter restarts at each conversion so the phase of the first tick is fixed
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_r <= 7'h00;
      tick <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r <= 7'h00;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      tick <= 1'b0;
    end
  end

endmodule

// >>> ars_pkg.sv
// package: register map, field layout and timing constants of the converter sequencer
package ars_pkg;

  localparam logic [3:0] ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B = 4'h4;
  localparam logic [3:0] ADDR_REF_CTRL = 4'h8;
  localparam logic [3:0] ADDR_PIN_CTRL = 4'hC;

  // control a: [7]=power enable (rw), [6]=busy (ro), [5]=start (rw), [3:0]=external channel
  localparam int CA_PWR = 7;
  localparam int CA_BUSY = 6;
  localparam int CA_START = 5;
  // control b: [6:4]=input source, [3:2]=reference select, [1:0] shares nothing: divider at [10:8]
  localparam int CB_SRC_LO = 4;
  localparam int CB_REF_LO = 2;
  localparam int CB_DIV_LO = 8;
  // reference control: [0]=temp sensor enable, [1]=path switch, [4:2]=regulator voltage,
  // [7:6]=pin function select; [8]=done flag (ro, write 1 clears)
  localparam int RC_TEMP_SENSOR_ENABLE = 0;
  localparam int RC_PSW = 1;
  localparam int RC_RV_LO = 2;
  localparam int RC_PF_LO = 6;
  localparam int RC_DONE = 8;

  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [10:0] CTRL_B_RST = 11'h000;
  localparam logic [7:0] REF_CTRL_RST = 8'h00;
  localparam logic [7:0] PIN_CTRL_RST = 8'h00;

  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_TEMP = 3'h2;
  localparam logic [2:0] SRC_AMP_OUT = 3'h3;
  localparam logic [2:0] SRC_AMP_POS = 3'h4;
  localparam logic [2:0] SRC_FORBID = 3'h7;

  localparam logic [1:0] REF_PIN_OR_REG = 2'h0;
  localparam logic [1:0] REF_TEMP = 2'h2;
  localparam logic [1:0] PF_REF_PIN = 2'h2;

  localparam logic [5:0] SAMPLE_NORMAL = 6'h04;
  localparam logic [5:0] SAMPLE_TEMP = 6'h2E;
  localparam logic [5:0] CONVERT_CLKS = 6'h0C;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } ars_state_t;

endpackage

// >>> ars_sequencer.sv
// converter control: power, reference routing, input select, pin override, conversion timing
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
module ars_sequencer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic converter_power_enable,
  output logic [1:0] ref_route,
  output logic [7:0] analog_pin_select,
  output logic [3:0] internal_source_select,
  output logic [7:0] pin_digital_disable,
  output logic [7:0] pin_pullup_disable,
  output logic sample_phase,
  output logic convert_phase,
  output logic conversion_done
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] ctrl_a_r;
  logic [10:0] ctrl_b_r;
  logic [7:0] ref_ctrl_r;
  logic [7:0] pin_ctrl_r;
  logic done_r;
  logic busy_r;
  logic start_prev_r;
  ars_pkg::ars_state_t state_r;
  logic [5:0] phase_cnt_r;
  logic [2:0] lat_src_r;
  logic [3:0] lat_chan_r;
  logic [1:0] lat_ref_r;
  logic [2:0] lat_div_r;
  logic lat_temp_r;
  logic tick;
  logic start_evt;
  logic finish_evt;

  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic wr_ok;
  logic [31:0] rd_val;
  logic rd_ok;

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
    merge8 = en ? nw : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data taken in either order, response after both

  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_ok = (aw_addr_r == ars_pkg::ADDR_CTRL_A) || (aw_addr_r == ars_pkg::ADDR_CTRL_B) ||
                 (aw_addr_r == ars_pkg::ADDR_REF_CTRL) || (aw_addr_r == ars_pkg::ADDR_PIN_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ars_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ars_pkg::RESP_OKAY : ars_pkg::RESP_SLVERR;
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_r <= ars_pkg::CTRL_A_RST;
      ctrl_b_r <= ars_pkg::CTRL_B_RST;
      ref_ctrl_r <= ars_pkg::REF_CTRL_RST;
      pin_ctrl_r <= ars_pkg::PIN_CTRL_RST;
    end else if (wr_go) begin
      if (aw_addr_r == ars_pkg::ADDR_CTRL_A) begin
        ctrl_a_r <= merge8(ctrl_a_r, w_data_r[7:0], w_strb_r[0]);
      end else if (aw_addr_r == ars_pkg::ADDR_CTRL_B) begin
        // a write carrying the forbidden source leaves the source field unchanged
        if (w_strb_r[0] && w_data_r[ars_pkg::CB_SRC_LO +: 3] != ars_pkg::SRC_FORBID) begin
          ctrl_b_r[7:0] <= w_data_r[7:0];
        end else if (w_strb_r[0]) begin
          ctrl_b_r[3:0] <= w_data_r[3:0];
        end
        if (w_strb_r[1]) begin
          ctrl_b_r[10:8] <= w_data_r[10:8];
        end
      end else if (aw_addr_r == ars_pkg::ADDR_REF_CTRL) begin
        ref_ctrl_r <= merge8(ref_ctrl_r, w_data_r[7:0], w_strb_r[0]);
      end else if (aw_addr_r == ars_pkg::ADDR_PIN_CTRL) begin
        pin_ctrl_r <= merge8(pin_ctrl_r, w_data_r[7:0], w_strb_r[0]);
      end
    end
  end

  // done flag: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_r <= 1'b0;
    end else if (finish_evt) begin
      done_r <= 1'b1;
    end else if (wr_go && aw_addr_r == ars_pkg::ADDR_REF_CTRL && w_strb_r[1] &&
                 w_data_r[ars_pkg::RC_DONE]) begin
      done_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr[3:2] == ars_pkg::ADDR_CTRL_A[3:2]) begin
      rd_val[7:0] = ctrl_a_r;
      rd_val[ars_pkg::CA_BUSY] = busy_r;
    end else if (s_axi_araddr[3:2] == ars_pkg::ADDR_CTRL_B[3:2]) begin
      rd_val[10:0] = ctrl_b_r;
    end else if (s_axi_araddr[3:2] == ars_pkg::ADDR_REF_CTRL[3:2]) begin
      rd_val[7:0] = ref_ctrl_r;
      rd_val[ars_pkg::RC_DONE] = done_r;
    end else begin
      rd_val[7:0] = pin_ctrl_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ars_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? ars_pkg::RESP_OKAY : ars_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start detection and conversion sequencing

  // falling edge of start after a high level begins a conversion; ignored while busy or while power enable is clear
  assign start_evt = start_prev_r && !ctrl_a_r[ars_pkg::CA_START] && !busy_r &&
                     ctrl_a_r[ars_pkg::CA_PWR];
  assign finish_evt = (state_r == ars_pkg::ST_CONVERT) && tick &&
                      (phase_cnt_r == ars_pkg::CONVERT_CLKS - 6'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_prev_r <= 1'b0;
    end else begin
      start_prev_r <= ctrl_a_r[ars_pkg::CA_START];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_src_r <= ars_pkg::SRC_EXT;
      lat_chan_r <= 4'h0;
      lat_ref_r <= ars_pkg::REF_PIN_OR_REG;
      lat_div_r <= 3'h0;
      lat_temp_r <= 1'b0;
    end else if (start_evt) begin
      lat_src_r <= ctrl_b_r[ars_pkg::CB_SRC_LO +: 3];
      lat_chan_r <= ctrl_a_r[3:0];
      lat_ref_r <= ctrl_b_r[ars_pkg::CB_REF_LO +: 2];
      lat_div_r <= ctrl_b_r[ars_pkg::CB_DIV_LO +: 3];
      lat_temp_r <= ctrl_b_r[ars_pkg::CB_SRC_LO +: 3] == ars_pkg::SRC_TEMP;
    end
  end

  ars_clk_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(busy_r || start_evt), // starts with the event so the first sampling period is whole
    .div_sel(start_evt ? ctrl_b_r[ars_pkg::CB_DIV_LO +: 3] : lat_div_r),
    .tick(tick)
  );

  // sequence runs from the divider ticks alone; software only waits for busy to drop
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl_a_r[ars_pkg::CA_PWR]) begin
      state_r <= ars_pkg::ST_IDLE;
      phase_cnt_r <= 6'h00;
      busy_r <= 1'b0;
    end else begin
      case (state_r)
        ars_pkg::ST_IDLE: begin
          if (start_evt) begin
            state_r <= ars_pkg::ST_SAMPLE;
            phase_cnt_r <= 6'h00;
            busy_r <= 1'b1;
          end
        end
        ars_pkg::ST_SAMPLE: begin
          if (tick) begin
            if (phase_cnt_r == (lat_temp_r ? ars_pkg::SAMPLE_TEMP : ars_pkg::SAMPLE_NORMAL)
                - 6'h01) begin
              state_r <= ars_pkg::ST_CONVERT;
              phase_cnt_r <= 6'h00;
            end else begin
              phase_cnt_r <= phase_cnt_r + 6'h01;
            end
          end
        end
        ars_pkg::ST_CONVERT: begin
          if (finish_evt) begin
            state_r <= ars_pkg::ST_IDLE;
            busy_r <= 1'b0;
          end else if (tick) begin
            phase_cnt_r <= phase_cnt_r + 6'h01;
          end
        end
        default: begin
          state_r <= ars_pkg::ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog routing outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_power_enable <= 1'b0;
      ref_route <= 2'h0;
      analog_pin_select <= 8'h00;
      internal_source_select <= 4'h0;
      pin_digital_disable <= 8'h00;
      pin_pullup_disable <= 8'h00;
      sample_phase <= 1'b0;
      convert_phase <= 1'b0;
      conversion_done <= 1'b0;
    end else begin
      converter_power_enable <= ctrl_a_r[ars_pkg::CA_PWR];
      // ref_route: 0 pin-or-regulator node, 1 analog supply, 2 temp sensor reference
      if (lat_ref_r == ars_pkg::REF_TEMP) begin
        ref_route <= 2'h2;
      end else if (lat_ref_r != ars_pkg::REF_PIN_OR_REG) begin
        ref_route <= 2'h1;
      end else begin
        ref_route <= 2'h0;
      end
      analog_pin_select <= 8'h00;
      internal_source_select <= 4'h0;
      if (busy_r) begin
        if (lat_src_r == ars_pkg::SRC_EXT || lat_src_r > ars_pkg::SRC_AMP_POS) begin
          if (!lat_chan_r[3]) begin
            analog_pin_select <= 8'h01 << lat_chan_r[2:0];
          end
        end else begin
          internal_source_select <= 4'h1 << (lat_src_r[1:0] - 2'h1);
        end
      end
      // pin override is a static function of the pin control register
      pin_digital_disable <= pin_ctrl_r;
      pin_pullup_disable <= pin_ctrl_r;
      sample_phase <= state_r == ars_pkg::ST_SAMPLE;
      convert_phase <= state_r == ars_pkg::ST_CONVERT;
      conversion_done <= finish_evt;
    end
  end

endmodule

// >>> tb_top.sv
// testbench: register-level regression of the converter sequencer
`timescale 1ns/100ps
module tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, internal_source_select;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, ref_route;
  logic converter_power_enable, sample_phase, convert_phase, conversion_done;
  logic [7:0] analog_pin_select, pin_digital_disable, pin_pullup_disable;
  int mismatches, compares, scnt, ccnt, dcnt;

  ars_sequencer dut (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    scnt <= scnt + int'(sample_phase);
    ccnt <= ccnt + int'(convert_phase);
    dcnt <= dcnt + int'(conversion_done);
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic tmo(input string nm);
    mismatches++;
    $display("MISMATCH %s expected handshake seen timeout", nm);
    close_out();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) tmo("bvalid");
    chk("bresp", ars_pkg::RESP_OKAY, s_axi_bresp);
    s_axi_bready <= 1'b0;
    // one idle edge so the next call never re-drives bready in this step
    @(posedge aclk);
  endtask
  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) tmo("rvalid");
    rv = s_axi_rdata;
    chk("rresp", ars_pkg::RESP_OKAY, s_axi_rresp);
    chk(nm, e, rv & m);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic conv(input logic [2:0] src, input logic [3:0] ch, input logic [1:0] rf,
                      input logic [2:0] dv);
    int s0, c0, d0, n;
    logic [7:0] ep;
    logic [3:0] ei;
    logic [1:0] er;
    ep = ((src == 0 || src == 5 || src == 6) && ch < 8) ? 8'h01 << ch : 8'h00;
    ei = (src >= 1 && src <= 4) ? 4'h1 << (src - 1) : 4'h0;
    er = (rf == 2'h2) ? 2'h2 : {1'b0, rf[0]};
    s0 = scnt;
    c0 = ccnt;
    d0 = dcnt;
    wr(ars_pkg::ADDR_CTRL_B, {21'h0, dv, 1'b0, src, rf, 2'b00}, 4'h3);
    wr(ars_pkg::ADDR_CTRL_A, {24'h0, 4'hA, ch});
    wr(ars_pkg::ADDR_CTRL_A, {24'h0, 4'h8, ch});
    for (n = 0; n < 20 && !sample_phase; n++) @(posedge aclk);
    if (n == 20) tmo("sample_phase");
    chk("pin select", ep, analog_pin_select);
    chk("internal select", ei, internal_source_select);
    chk("ref route", er, ref_route);
    rchk("busy set", ars_pkg::ADDR_CTRL_A, 32'h40, 32'h40);
    wr(ars_pkg::ADDR_CTRL_B, 32'h034, 4'h3);
    if (sample_phase || convert_phase) chk("held select", ep, analog_pin_select);
    if (sample_phase || convert_phase) chk("held ref", er, ref_route);
    if (sample_phase || convert_phase) chk("held internal", ei, internal_source_select);
    for (n = 0; n < 5000 && !conversion_done; n++) @(posedge aclk);
    if (n == 5000) tmo("conversion_done");
    @(posedge aclk);
    chk("sample len", ((src == 2) ? 46 : 4) << dv, scnt - s0);
    chk("convert len", 12 << dv, ccnt - c0);
    chk("done pulses", 1, dcnt - d0);
    rchk("busy clear", ars_pkg::ADDR_CTRL_A, 32'h40, 32'h00);
    rchk("done flag", ars_pkg::ADDR_REF_CTRL, 32'h100, 32'h100);
    wr(ars_pkg::ADDR_REF_CTRL, 32'h100, 4'h2);
    rchk("done cleared", ars_pkg::ADDR_REF_CTRL, 32'h1FF, 32'h001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    static logic [2:0] st [8] = '{0, 0, 1, 2, 3, 4, 5, 6};
    static logic [3:0] ct [8] = '{3, 9, 8, 8, 8, 8, 7, 0};
    static logic [2:0] dt [8] = '{0, 1, 0, 0, 2, 1, 0, 7};
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("power at reset", 0, converter_power_enable);
    for (int a = 0; a < 16; a += 4) rchk("reset value", a[3:0], 32'hFFFFFFFF, 0);
    rchk("unaligned", 4'h2, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    wr(ars_pkg::ADDR_PIN_CTRL, 32'hA5);
    repeat (2) @(posedge aclk);
    chk("digital disable", 8'hA5, pin_digital_disable);
    chk("pullup disable", 8'hA5, pin_pullup_disable);
    rchk("unaligned pin", 4'hE, 32'hFF, 32'hA5);
    $display("test pin override done");
    wr(ars_pkg::ADDR_CTRL_A, 32'h20);
    wr(ars_pkg::ADDR_CTRL_A, 32'h00);
    repeat (30) @(posedge aclk);
    chk("unpowered start", 0, scnt);
    $display("test unpowered start done");
    // power first and let the analog side settle before any start
    wr(ars_pkg::ADDR_CTRL_A, 32'h80);
    repeat (20) @(posedge aclk);
    // temp sensor on, path switch clear, reference pin function off
    wr(ars_pkg::ADDR_REF_CTRL, 32'h01);
    for (int i = 0; i < 8; i++) conv(st[i], ct[i], i[1:0], dt[i]);
    chk("power on", 1, converter_power_enable);
    $display("test conversions done");
    wr(ars_pkg::ADDR_CTRL_B, 32'h070, 4'h3);
    rchk("forbidden source", ars_pkg::ADDR_CTRL_B, 32'h70, 32'h30);
    // select is now 00: reference pin setup, then regulator path with voltage 010
    wr(ars_pkg::ADDR_REF_CTRL, 32'h80);
    rchk("ref pin setup", ars_pkg::ADDR_REF_CTRL, 32'hFF, 32'h80);
    wr(ars_pkg::ADDR_REF_CTRL, 32'h0A);
    rchk("regulator setup", ars_pkg::ADDR_REF_CTRL, 32'hFF, 32'h0A);
    wr(ars_pkg::ADDR_CTRL_A, 32'h00);
    repeat (2) @(posedge aclk);
    chk("power off", 0, converter_power_enable);
    $display("test forbidden source and power down done");
    close_out();
  end
endmodule
